// ### shared/sup_pkg.sv
// Constants for the process-loop supervisor: register map, fields, codes, timing.
// Assumes a 50 MHz core clock and 32-bit AHB-Lite register access.
package sup_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SWITCH  = 8'h04;
  localparam logic [7:0] OFS_DTIME   = 8'h08;
  localparam logic [7:0] OFS_DLEVEL  = 8'h0c;
  localparam logic [7:0] OFS_CANCEL  = 8'h10;
  localparam logic [7:0] OFS_BIASGN  = 8'h14;
  localparam logic [7:0] OFS_MINMAX  = 8'h18;
  localparam logic [7:0] OFS_TERM    = 8'h1c;
  localparam logic [7:0] OFS_MONSEL  = 8'h20;
  localparam logic [7:0] OFS_STATUS  = 8'h24;
  localparam logic [7:0] OFS_ISTAT   = 8'h28;
  localparam logic [7:0] OFS_ICLR    = 8'h2c;
  localparam logic [7:0] OFS_IEN     = 8'h30;
  // ==========================================================
  // Control register fields
  localparam int CTRL_ASSIGN = 8;
  localparam int CTRL_PFS    = 9;
  localparam int CTRL_SLEEP  = 10;
  localparam int CTRL_MODE   = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ==========================================================
  // Codes and limits; frequency in 0.01 Hz, percent in 0.1 %
  localparam logic [15:0] SWITCH_MAX  = 16'h9c40;
  localparam logic [3:0]  MODE_SWITCH = 4'h6;
  localparam logic [7:0]  MON_SP      = 8'h34;
  localparam logic [7:0]  MON_MV      = 8'h35;
  localparam logic [7:0]  MON_DEV     = 8'h36;
  localparam logic [7:0]  FN_LOOP     = 8'h2f;
  localparam logic [7:0]  FN_SLEEP    = 8'h46;
  localparam logic [7:0]  FN_INVERT   = 8'h64;
  localparam logic [11:0] DEV_ZERO    = 12'h3e8;
  localparam logic [11:0] PCT_FULL    = 12'h3e8;
  localparam logic [15:0] MAX_RST     = 16'hffff;
  // ==========================================================
  // Interrupt bits
  localparam int IRQ_CLOSE  = 0;
  localparam int IRQ_SLEEP  = 1;
  localparam int IRQ_WAKE   = 2;
  localparam int IRQ_REFUSE = 3;
  localparam int IRQ_W      = 4;
  // ==========================================================
  // Timing: sleep timer counts in 1 ms ticks
  localparam int CLK_NS     = 20;
  localparam int TICK_US    = 1000;
  localparam int TICK_CYC   = TICK_US * 1000 / CLK_NS;
  typedef enum logic [2:0] {ST_IDLE, ST_OPEN, ST_CLOSED, ST_SLEEP} sup_state_t;
endpackage

// ### src/sleep_timer.sv
// Sleep detection timer: counts ms ticks while the loop output stays low.
// Assumes inputs from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sleep_timer #(
  parameter int TICK = sup_pkg::TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        arm,
  input  wire logic        below,
  input  wire logic [15:0] limit,
  output logic             trip
);
  logic [31:0] pre;
  logic [15:0] ms;
  // ==========================================================
  // Prescaler and ms counter; restart whenever output rises again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 32'h0;
      ms  <= 16'h0;
    end else if (!arm || !below) begin // see [RULE_18]
      pre <= 32'h0;
      ms  <= 16'h0;
    end else if (pre == 32'(TICK - 1)) begin
      pre <= 32'h0;
      if (ms != 16'hffff) ms <= ms + 16'h1;
    end else begin
      pre <= pre + 32'h1;
    end
  end
  // Trip once the low stretch is longer than the limit
  assign trip = arm && below && (ms > limit); // see [RULE_03]
  chk_trip_needs_low : assert property (@(posedge clk) disable iff (!rst_n)
    trip |-> below && $past(below)) else $error("trip without low output"); // see [RULE_18]
endmodule
`default_nettype wire

// ### src/term_drive.sv
// Output terminal mapping: function code picks a signal and its polarity.
// Assumes codes are held stable in registers of the same clock.
`timescale 1ns/100ps
`default_nettype none
module term_drive (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] code,
  input  wire logic       loop_active,
  input  wire logic       sleep,
  output logic            pin
);
  // ==========================================================
  // Base function and polarity; codes of 100 and up invert
  function automatic logic pick(input logic [7:0] c, input logic la, input logic sl);
    logic [7:0] base;
    logic       v;
    base = (c >= sup_pkg::FN_INVERT) ? c - sup_pkg::FN_INVERT : c;
    v    = (base == sup_pkg::FN_SLEEP) ? sl : (base == sup_pkg::FN_LOOP) ? la : 1'b0;
    return (c >= sup_pkg::FN_INVERT) ? !v : v; // see [RULE_17]
  endfunction
  // Registered so the pin never glitches on a code change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pin <= 1'b0;
    else pin <= pick(code, loop_active, sleep); // see [RULE_06]
  end
  chk_sleep_low_code : assert property (@(posedge clk) disable iff (!rst_n)
    (code == sup_pkg::FN_INVERT + sup_pkg::FN_SLEEP) && sleep |=> !pin)
    else $error("negative sleep pin high"); // see [RULE_06]
endmodule
`default_nettype wire

// ### src/pid_supervisor.sv
// Supervisor around a process-loop controller: start handover, sleep, monitors.
// Assumes OUT_FREQ, LOOP_FREQ, SET_POINT and MEASURED come from same-clock logic.
// How it works
// [RULE_01] Open loop until output reaches switchover
// [RULE_02] Closed loop stays despite low frequency
// [RULE_03] Sustained low loop output enters sleep
// [RULE_04] Deviation reaching cancel level wakes loop
// [RULE_05] Sleep: sleep on, run off, loop on
// [RULE_06] Sleep on terminal code 70 or 170
// [RULE_07] Monitor codes 52, 53, 54 select values
// [RULE_08] Deviation shown with 1000 at zero
// [RULE_09] Deviation refused for analog monitor
// [RULE_10] Analog monitor: 100 percent is full scale
// [RULE_11] Step speed or inching overrides loop
// [RULE_12] Mode 6 or power-fail stop disables loop
// [RULE_13] Clamp to bias/gain and min/max
// [RULE_14] Remote speed ignored while loop active
// [RULE_15] Loop command restarts from zero
// [RULE_16] Unassigned enable: action setting alone
// [RULE_17] Codes 100 and up drive active low
// [RULE_18] Timer restarts when output recovers
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pid_supervisor #(
  parameter int          TICK_CYCLES = sup_pkg::TICK_CYC,
  parameter logic [11:0] AM_FULL     = 12'h3ff
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        RUN_CMD,
  input  wire logic        LOOP_ENABLE_INPUT,
  input  wire logic        SPEED_SELECT_HIGH,
  input  wire logic        SPEED_SELECT_MID,
  input  wire logic        SPEED_SELECT_LOW,
  input  wire logic        SPEED_SELECT_EXTENDED,
  input  wire logic        INCH_INPUT,
  input  wire logic [15:0] OUT_FREQ,
  input  wire logic [15:0] LOOP_FREQ,
  input  wire logic [15:0] BASE_FREQ,
  input  wire logic [15:0] REMOTE_FREQ,
  input  wire logic        REMOTE_ACTIVE,
  input  wire logic [11:0] SET_POINT,
  input  wire logic [11:0] MEASURED,
  output logic [15:0]      FREQ_CMD,
  output logic             LOOP_RESTART,
  output logic             RUN_FLAG,
  output logic             SLEEP_FLAG,
  output logic             LOOP_ACTIVE_FLAG,
  output logic [2:0]       OUTPUT_TERMINAL,
  output logic [11:0]      DISPLAY_VALUE,
  output logic [11:0]      ANALOG_MONITOR_OUTPUT,
  output logic             IRQ
);
  // ==========================================================
  // Registers
  logic [31:0] ctrl;
  logic [15:0] switchover_frequency, interruption_detect_time, interruption_detect_level;
  logic [11:0] interruption_cancel_level;
  logic [15:0] bias_point_frequency, gain_point_frequency, min_freq, max_freq;
  logic [7:0]  output_terminal_function_a, output_terminal_function_b;
  logic [7:0]  output_terminal_function_c;
  logic [7:0]  main_display_select, analog_monitor_select;
  logic [sup_pkg::IRQ_W-1:0] irq_stat, irq_en, irq_set;
  sup_pkg::sup_state_t state;
  // ==========================================================
  // AHB-Lite slave: zero wait, always OKAY
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       ap_valid;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign ap_valid  = HSEL && HREADY && HTRANS[1];
  // Capture write address phase; data follows next cycle
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else begin
      wr_pend <= ap_valid && HWRITE;
      wr_addr <= HADDR[7:0];
    end
  end
  // Register writes; out-of-range switchover clamps to its top value
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= sup_pkg::CTRL_RST;
      switchover_frequency <= 16'h0;
      interruption_detect_time <= 16'h0;
      interruption_detect_level <= 16'h0;
      interruption_cancel_level <= sup_pkg::DEV_ZERO;
      bias_point_frequency <= 16'h0;
      gain_point_frequency <= sup_pkg::MAX_RST;
      min_freq <= 16'h0;
      max_freq <= sup_pkg::MAX_RST;
      output_terminal_function_a <= 8'h0;
      output_terminal_function_b <= 8'h0;
      output_terminal_function_c <= 8'h0;
      main_display_select <= sup_pkg::MON_SP;
      analog_monitor_select <= sup_pkg::MON_SP;
      irq_en <= '0;
    end else if (wr_pend) begin
      case (wr_addr)
        sup_pkg::OFS_CTRL: ctrl <= HWDATA;
        sup_pkg::OFS_SWITCH: switchover_frequency <= (HWDATA[15:0] > sup_pkg::SWITCH_MAX) ?
            sup_pkg::SWITCH_MAX : HWDATA[15:0]; // see [RULE_01]
        sup_pkg::OFS_DTIME: interruption_detect_time <= HWDATA[15:0];
        sup_pkg::OFS_DLEVEL: interruption_detect_level <= HWDATA[15:0];
        sup_pkg::OFS_CANCEL: interruption_cancel_level <= HWDATA[11:0];
        sup_pkg::OFS_BIASGN: begin
          bias_point_frequency <= HWDATA[15:0];
          gain_point_frequency <= HWDATA[31:16];
        end
        sup_pkg::OFS_MINMAX: begin
          min_freq <= HWDATA[15:0];
          max_freq <= HWDATA[31:16];
        end
        sup_pkg::OFS_TERM: begin
          output_terminal_function_a <= HWDATA[7:0];
          output_terminal_function_b <= HWDATA[15:8];
          output_terminal_function_c <= HWDATA[23:16];
        end
        sup_pkg::OFS_MONSEL: begin
          main_display_select <= HWDATA[7:0];
          if (HWDATA[15:8] != sup_pkg::MON_DEV) begin // see [RULE_09]
            analog_monitor_select <= HWDATA[15:8];
          end
        end
        sup_pkg::OFS_IEN: irq_en <= HWDATA[sup_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end
  // Read data registered in the address phase; unmapped reads zero
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HRDATA <= 32'h0;
    end else if (ap_valid && !HWRITE) begin
      case (HADDR[7:0])
        sup_pkg::OFS_CTRL:   HRDATA <= ctrl;
        sup_pkg::OFS_SWITCH: HRDATA <= {16'h0, switchover_frequency};
        sup_pkg::OFS_DTIME:  HRDATA <= {16'h0, interruption_detect_time};
        sup_pkg::OFS_DLEVEL: HRDATA <= {16'h0, interruption_detect_level};
        sup_pkg::OFS_CANCEL: HRDATA <= {20'h0, interruption_cancel_level};
        sup_pkg::OFS_BIASGN: HRDATA <= {gain_point_frequency, bias_point_frequency};
        sup_pkg::OFS_MINMAX: HRDATA <= {max_freq, min_freq};
        sup_pkg::OFS_TERM:   HRDATA <= {8'h0, output_terminal_function_c,
                                        output_terminal_function_b, output_terminal_function_a};
        sup_pkg::OFS_MONSEL: HRDATA <= {16'h0, analog_monitor_select, main_display_select};
        sup_pkg::OFS_STATUS: HRDATA <= {4'h0, DISPLAY_VALUE, 10'h0, LOOP_ACTIVE_FLAG,
                                        SLEEP_FLAG, RUN_FLAG, 3'(state)};
        sup_pkg::OFS_ISTAT:  HRDATA <= {28'h0, irq_stat};
        sup_pkg::OFS_IEN:    HRDATA <= {28'h0, irq_en};
        default:             HRDATA <= 32'h0;
      endcase
    end
  end
  // ==========================================================
  // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
  logic [5:0] s1, s2, s3, pins;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s1 <= 6'h0;
      s2 <= 6'h0;
      s3 <= 6'h0;
      pins <= 6'h0;
    end else begin
      s1 <= {RUN_CMD, LOOP_ENABLE_INPUT, SPEED_SELECT_HIGH, SPEED_SELECT_MID,
             SPEED_SELECT_LOW, SPEED_SELECT_EXTENDED | INCH_INPUT};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 6; i++) begin
        if (s2[i] == s3[i]) pins[i] <= s3[i];
      end
    end
  end
  // ==========================================================
  // Loop validity and overrides
  logic run, loop_en, override, loop_valid, pfs_stop;
  assign run      = pins[5];
  // Unassigned enable terminal means the action setting alone decides
  assign loop_en  = ctrl[sup_pkg::CTRL_ASSIGN] ? pins[4] : 1'b1; // see [RULE_16]
  assign override = loop_en && (|pins[3:0]); // see [RULE_11]
  assign pfs_stop = ctrl[sup_pkg::CTRL_PFS] && !run;
  assign loop_valid = (ctrl[7:0] != 8'h0) && loop_en && !pfs_stop &&
      (ctrl[sup_pkg::CTRL_MODE +: 4] != sup_pkg::MODE_SWITCH); // see [RULE_12]
  // ==========================================================
  // Deviation with offset so negatives show; cancel level shares the offset
  logic [11:0] dev_disp;
  logic        wake, trip;
  assign dev_disp = sup_pkg::DEV_ZERO + SET_POINT - MEASURED; // see [RULE_08]
  assign wake = $signed({1'b0, dev_disp}) >= $signed({1'b0, interruption_cancel_level}); // see [RULE_04]
  sleep_timer #(.TICK(TICK_CYCLES)) u_sleep (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .arm   ((state == sup_pkg::ST_CLOSED) && ctrl[sup_pkg::CTRL_SLEEP]),
    .below (LOOP_FREQ < interruption_detect_level),
    .limit (interruption_detect_time),
    .trip  (trip)
  );
  // ==========================================================
  // Supervisory state machine; normal operation wins whenever loop is invalid
  sup_pkg::sup_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      sup_pkg::ST_IDLE:
        if (run && loop_valid && !override) begin
          next_state = (switchover_frequency != 16'h0) ? sup_pkg::ST_OPEN : sup_pkg::ST_CLOSED;
        end
      sup_pkg::ST_OPEN:
        if (OUT_FREQ >= switchover_frequency) next_state = sup_pkg::ST_CLOSED; // see [RULE_01]
      sup_pkg::ST_CLOSED:
        if (trip) next_state = sup_pkg::ST_SLEEP; // see [RULE_02]
      sup_pkg::ST_SLEEP:
        if (wake) next_state = sup_pkg::ST_CLOSED;
      default: next_state = sup_pkg::ST_IDLE;
    endcase
    if (!run || !loop_valid || override) next_state = sup_pkg::ST_IDLE;
  end
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) state <= sup_pkg::ST_IDLE;
    else state <= next_state;
  end
  // ==========================================================
  // Frequency command and indications
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction
  logic entering;
  assign entering = (next_state == sup_pkg::ST_CLOSED) && (state != sup_pkg::ST_CLOSED) &&
                    (state != sup_pkg::ST_SLEEP);
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FREQ_CMD <= 16'h0;
      LOOP_RESTART <= 1'b0;
      RUN_FLAG <= 1'b0;
      SLEEP_FLAG <= 1'b0;
      LOOP_ACTIVE_FLAG <= 1'b0;
    end else begin
      LOOP_RESTART <= entering; // see [RULE_15]
      RUN_FLAG <= run && (next_state != sup_pkg::ST_SLEEP); // see [RULE_05]
      SLEEP_FLAG <= next_state == sup_pkg::ST_SLEEP;
      LOOP_ACTIVE_FLAG <= (next_state == sup_pkg::ST_CLOSED) ||
                          (next_state == sup_pkg::ST_SLEEP);
      case (next_state)
        // Old command dropped: the loop restarts from 0 Hz on entry
        sup_pkg::ST_CLOSED: FREQ_CMD <= entering ? 16'h0 : clamp(clamp(LOOP_FREQ,
            bias_point_frequency, gain_point_frequency), min_freq, max_freq); // see [RULE_13]
        sup_pkg::ST_SLEEP: FREQ_CMD <= 16'h0;
        // Remote setting only counts outside loop operation
        default: FREQ_CMD <= (REMOTE_ACTIVE && next_state == sup_pkg::ST_IDLE) ?
            REMOTE_FREQ : BASE_FREQ; // see [RULE_14]
      endcase
    end
  end
  // ==========================================================
  // Output terminals
  term_drive u_ta (.clk(CORE_CLK), .rst_n(RESET_N), .code(output_terminal_function_a),
    .loop_active(LOOP_ACTIVE_FLAG), .sleep(SLEEP_FLAG), .pin(OUTPUT_TERMINAL[0]));
  term_drive u_tb (.clk(CORE_CLK), .rst_n(RESET_N), .code(output_terminal_function_b),
    .loop_active(LOOP_ACTIVE_FLAG), .sleep(SLEEP_FLAG), .pin(OUTPUT_TERMINAL[1]));
  term_drive u_tc (.clk(CORE_CLK), .rst_n(RESET_N), .code(output_terminal_function_c),
    .loop_active(LOOP_ACTIVE_FLAG), .sleep(SLEEP_FLAG), .pin(OUTPUT_TERMINAL[2]));
  // ==========================================================
  // Monitors in 0.1 % steps; analog full scale at 100 %
  logic [11:0] am_src;
  logic [23:0] am_prod;
  assign am_src  = (analog_monitor_select == sup_pkg::MON_MV) ? MEASURED : SET_POINT;
  assign am_prod = ((am_src > sup_pkg::PCT_FULL) ? sup_pkg::PCT_FULL : am_src) * AM_FULL;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DISPLAY_VALUE <= 12'h0;
      ANALOG_MONITOR_OUTPUT <= 12'h0;
    end else begin
      case (main_display_select) // see [RULE_07]
        sup_pkg::MON_SP:  DISPLAY_VALUE <= SET_POINT;
        sup_pkg::MON_MV:  DISPLAY_VALUE <= MEASURED;
        sup_pkg::MON_DEV: DISPLAY_VALUE <= dev_disp;
        default:          DISPLAY_VALUE <= 12'h0;
      endcase
      ANALOG_MONITOR_OUTPUT <= 12'(am_prod / 24'(sup_pkg::PCT_FULL)); // see [RULE_10]
    end
  end
  // ==========================================================
  // Sticky interrupts; a set in the clear cycle survives
  assign irq_set = {wr_pend && wr_addr == sup_pkg::OFS_MONSEL && HWDATA[15:8] == sup_pkg::MON_DEV,
                    state == sup_pkg::ST_SLEEP && next_state == sup_pkg::ST_CLOSED,
                    state == sup_pkg::ST_CLOSED && next_state == sup_pkg::ST_SLEEP,
                    entering};
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) irq_stat <= '0;
    else if (wr_pend && wr_addr == sup_pkg::OFS_ICLR)
      irq_stat <= (irq_stat & ~HWDATA[sup_pkg::IRQ_W-1:0]) | irq_set;
    else irq_stat <= irq_stat | irq_set;
  end
  assign IRQ = |(irq_stat & irq_en);
  // ==========================================================
  // Checks
  chk_open_handover : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == sup_pkg::ST_OPEN && OUT_FREQ >= switchover_frequency && run && loop_valid && !override
    |=> state == sup_pkg::ST_CLOSED) else $error("no handover at switchover"); // see [RULE_01]
  chk_closed_stays : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == sup_pkg::ST_CLOSED && !trip && run && loop_valid && !override
    |=> state == sup_pkg::ST_CLOSED) else $error("left loop without cause"); // see [RULE_02]
  chk_sleep_entry : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == sup_pkg::ST_CLOSED && trip && run && loop_valid && !override
    |=> state == sup_pkg::ST_SLEEP) else $error("sleep not entered"); // see [RULE_03]
  chk_wake_level : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $past(state) == sup_pkg::ST_SLEEP && state == sup_pkg::ST_CLOSED |-> $past(wake))
    else $error("woke below cancel level"); // see [RULE_04]
  chk_sleep_flags : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == sup_pkg::ST_SLEEP |-> SLEEP_FLAG && !RUN_FLAG && LOOP_ACTIVE_FLAG)
    else $error("sleep indications wrong"); // see [RULE_05]
  chk_dev_zero : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    main_display_select == sup_pkg::MON_DEV && SET_POINT == MEASURED ##1
    $stable(main_display_select) && $stable(SET_POINT) && $stable(MEASURED)
    |-> DISPLAY_VALUE == sup_pkg::DEV_ZERO) else $error("zero deviation not 1000"); // see [RULE_08]
  chk_am_refuse : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    analog_monitor_select != sup_pkg::MON_DEV) else $error("deviation on analog"); // see [RULE_09]
  chk_override : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    override |=> state == sup_pkg::ST_IDLE && !LOOP_ACTIVE_FLAG) else $error("override lost"); // see [RULE_11]
  chk_mode_invalid : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ctrl[sup_pkg::CTRL_MODE +: 4] == sup_pkg::MODE_SWITCH |=> state == sup_pkg::ST_IDLE)
    else $error("loop in switchover mode"); // see [RULE_12]
  chk_clamp : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == sup_pkg::ST_CLOSED && !$past(entering) && bias_point_frequency <= gain_point_frequency
    && min_freq <= max_freq |-> FREQ_CMD <= max_freq) else $error("above max in loop"); // see [RULE_13]
  chk_restart_zero : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    entering |=> LOOP_RESTART && FREQ_CMD == 16'h0) else $error("no restart from 0"); // see [RULE_15]
endmodule
`default_nettype wire

// ### sim/drive_stage_model.sv
// Partner model of the drive output stage that feeds back the output frequency.
// Assumes the supervisor's clock, reset and registered command outputs.
`timescale 1ns/100ps
`default_nettype none
module drive_stage_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [15:0] cmd,
  output logic [15:0]      out_freq
);
  // ==========================================================
  // Output stage
  // Ramps 1 Hz a cycle; stops dead when not running, harsher than a real coast
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) out_freq <= 16'h0000;
    else if (!run) out_freq <= 16'h0000;
    else if (out_freq < cmd) out_freq <= out_freq + 16'h0064;
    else out_freq <= cmd;
  end
endmodule
`default_nettype wire

// ### sim/pid_supervisory_control_bench.sv
// Self-checking bench for the supervisor: bus setup, start, sleep, monitors, overrides.
// Assumes the supervisor, its package and the drive stage model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pid_supervisory_control_bench;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk = 1'b0, rst_n = 1'b0, run = 1'b0, hwrite = 1'b0, hready, irq;
  logic        f_run, f_sl, f_lp, len = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  term;
  logic [4:0]  ovr = 5'h00;
  logic [11:0] sp = 12'h190, mv = 12'h258, disp, am;
  logic [15:0] loop_f = 16'h0000, base_f = 16'h1770, rem_f = 16'h0000, out_f, cmd;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
  logic [39:0] cfg [7] = '{40'h30_0000_000f, 40'h04_0000_07d0, 40'h08_0000_0002,
    40'h0c_0000_0320, 40'h14_0bb8_03e8, 40'h1c_002f_aa46, 40'h00_0000_0501};
  int          err_total = 0, num_checks = 0, a, b;
  always #10 clk = ~clk;
  pid_supervisor #(.TICK_CYCLES(5)) i_pid_supervisor (.CORE_CLK(clk), .RESET_N(rst_n),
    .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
    .RUN_CMD(run), .LOOP_ENABLE_INPUT(len), .SPEED_SELECT_HIGH(ovr[0]),
    .SPEED_SELECT_MID(ovr[1]), .SPEED_SELECT_LOW(ovr[2]), .SPEED_SELECT_EXTENDED(ovr[3]),
    .INCH_INPUT(ovr[4]), .OUT_FREQ(out_f), .LOOP_FREQ(loop_f), .BASE_FREQ(base_f),
    .REMOTE_FREQ(rem_f), .REMOTE_ACTIVE(1'b1), .SET_POINT(sp), .MEASURED(mv),
    .FREQ_CMD(cmd), .LOOP_RESTART(), .RUN_FLAG(f_run), .SLEEP_FLAG(f_sl),
    .LOOP_ACTIVE_FLAG(f_lp), .OUTPUT_TERMINAL(term), .DISPLAY_VALUE(disp),
    .ANALOG_MONITOR_OUTPUT(am), .IRQ(irq));
  drive_stage_model i_drive_stage_model (.clk(clk), .rst_n(rst_n), .run(f_run), .cmd(cmd),
    .out_freq(out_f));
  // ==========================================================
  // Shared tasks
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // Address phase held until ready, then data phase; read data taken at its edge
  task bus(input logic w, input logic [7:0] a8, input logic [31:0] d);
    haddr <= {24'h0, a8};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask
  task rd_chk(input string n, input logic [7:0] a8, input logic [31:0] x);
    bus(1'b0, a8, 32'h0);
    chk(n, x, rdata);
  endtask
  // Polls the state field with a bounded count instead of assuming a latency
  task wait_st(input logic [2:0] s);
    bus(1'b0, sup_pkg::OFS_STATUS, 32'h0);
    for (int i = 0; i < 200 && rdata[2:0] !== s; i++) bus(1'b0, sup_pkg::OFS_STATUS, 32'h0);
    chk("state", {29'h0, s}, {29'h0, rdata[2:0]});
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Watchdog, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict;
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h1f4c));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rem_f <= 16'($urandom);
    @(posedge clk);
    rd_chk("ctrl", sup_pkg::OFS_CTRL, sup_pkg::CTRL_RST);
    rd_chk("cancel", sup_pkg::OFS_CANCEL, 32'h3e8);
    rd_chk("unmapped", 8'h40, 32'h0);
    foreach (cfg[i]) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
    run <= 1'b1;
    loop_f <= 16'h1388;
    wait_st(3'h1);
    wait_st(3'h2);
    repeat (3) @(posedge clk);
    chk("clamp", 32'hbb8, {16'h0, cmd});
    chk("irq", 32'h1, {31'h0, irq});
    loop_f <= 16'h01f4;
    wait_st(3'h3);
    repeat (2) @(posedge clk);
    chk("flags", 32'h5, {29'h0, f_sl, f_run, f_lp});
    chk("term", 32'h5, {29'h0, term});
    sp <= 12'h2bc;
    loop_f <= 16'h1388;
    wait_st(3'h2);
    for (int c = 0; c < 3; c++) begin
      a = $urandom_range(1000);
      b = $urandom_range(1000);
      sp <= 12'(a);
      mv <= 12'(b);
      bus(1'b1, sup_pkg::OFS_MONSEL, 32'(16'h3434 + c));
      repeat (2) @(posedge clk);
      a = (c == 0) ? a : (c == 1) ? b : 1000 + a - b;
      chk("display", 32'(a), {20'h0, disp});
    end
    sp <= 12'h3e8;
    mv <= 12'h3e8;
    repeat (2) @(posedge clk);
    chk("dev zero", 32'h3e8, {20'h0, disp});
    bus(1'b1, sup_pkg::OFS_MONSEL, 32'h3434);
    repeat (2) @(posedge clk);
    chk("analog", 32'h3ff, {20'h0, am});
    bus(1'b1, sup_pkg::OFS_MONSEL, 32'h3634);
    rd_chk("monsel", sup_pkg::OFS_MONSEL, 32'h3434);
    rd_chk("istat", sup_pkg::OFS_ISTAT, 32'hf);
    bus(1'b1, sup_pkg::OFS_ICLR, 32'hf);
    rd_chk("cleared", sup_pkg::OFS_ISTAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    for (int k = 0; k < 5; k++) begin
      ovr <= 5'(1 << k);
      wait_st(3'h0);
      ovr <= 5'h00;
      wait_st(3'h2);
    end
    // Enable pin low stops an assigned loop; unassigned, the action setting decides
    len <= 1'b0;
    wait_st(3'h0);
    bus(1'b1, sup_pkg::OFS_CTRL, 32'h0000_0401);
    wait_st(3'h2);
    bus(1'b1, sup_pkg::OFS_CTRL, 32'h0006_0401);
    wait_st(3'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
